// [design/vipu_pkg.sv]
// Constants, register map and vector table for the vectored interrupt unit
// Assumes a 32-bit APB slave on a single 125 MHz clock
package vipu_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CMN_IE_OFS = 8'h00;
  localparam logic [7:0] CMN_IFG_OFS = 8'h04;
  localparam logic [7:0] PORT_IFG_OFS = 8'h08;
  localparam logic [7:0] PORT_IE_OFS = 8'h0C;
  localparam logic [7:0] PORT_IES_OFS = 8'h10;
  localparam logic [7:0] TP_CTL_OFS = 8'h14;
  localparam logic [7:0] TP_STAT_OFS = 8'h18;
  localparam logic [7:0] CORE_CTL_OFS = 8'h1C;
  localparam logic [7:0] VEC_OFS = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;

  // ****************************************
  // Common flag area bit positions
  // ****************************************
  localparam int WDT_BIT = 0;
  localparam int OF_BIT = 1;
  localparam int P0_BIT = 2;
  localparam int P1_BIT = 3;
  localparam int BT_BIT = 4;
  localparam int CMN_W = 5;

  // ****************************************
  // Vector table and priorities
  // ****************************************
  localparam logic [15:0] VEC_BASE = 16'hFFE0;
  localparam logic [15:0] VEC_TOP = 16'hFFFF;
  localparam logic [3:0] PRI_RESET = 4'hF;
  localparam logic [3:0] PRI_NMI = 4'hE;
  localparam logic [3:0] PRI_P0 = 4'hD;
  localparam logic [3:0] PRI_P1 = 4'hC;
  localparam logic [3:0] PRI_WDT = 4'hA;
  localparam logic [3:0] PRI_TP = 4'h5;
  localparam logic [3:0] PRI_BT = 4'h1;
  localparam logic [3:0] PRI_PORTHI = 4'h0;

  // ****************************************
  // Reset values and misc
  // ****************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] ERR_DATA = 32'hDEAD_0000;
  localparam int EV_W = 3;

  typedef enum logic [1:0] {CORE_RUN, CORE_ACK, CORE_SLEEP} vipu_core_t;

endpackage

// [design/vipu_top.sv]
// Vectored interrupt priority unit: flags, enables, arbitration, vector fetch
// Assumes an APB master, a core using takeIrq/retIrq, synchronous inputs
//
// Contract
// - Vector words live at FFE0..FFFF, each a 16-bit handler address.
// - Power-up, external reset and watchdog expiry use FFFE, priority 15.
// - NMI and oscillator fault share FFFC, priority 14; fault maskable.
// - Port bit 0 at FFFA priority 13, bit 1 at FFF8 priority 12.
// - Timer/port common request FFEA priority 5, flags in own registers.
// - Split counters: gate, first overflow or second overflow set flag.
// - Cascaded counters: only gate or upper overflow sets flag.
// - Gate event stopping counter with external gate sets flag.
// - Six-bit port flag and enable for bits 2..7; bits 0,1 common.
// - Each port bit has edge interrupt with per-bit edge select.
// - Unassigned flag-area bits hold no storage, read zero.
// - Pending interrupt wakes sleep; return from acknowledge resumes run mode.
`timescale 1ns/1ps
module vipu_top
  import vipu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extResetReq,
  input wire logic wdtExpire,
  input wire logic wdtInterval,
  input wire logic nmiReq,
  input wire logic oscFault,
  input wire logic baseTimerTick,
  input wire logic [7:0] portPins,
  input wire logic tpGate,
  input wire logic tpOvfLow,
  input wire logic tpOvfHigh,
  input wire logic globalIrqEnable,
  input wire logic sleepReq,
  input wire logic takeIrq,
  input wire logic retIrq,
  output logic irqPending,
  output logic [15:0] vectorAddr,
  output logic [3:0] vectorPri,
  output logic coreAwake,
  output logic irq
);

  // ****************************************
  // Decode helper
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [CMN_W-1:0] cmnIe_q, cmnIe_d, cmnIfg_q, cmnIfg_d;
  logic [5:0] portIfg_q, portIfg_d, portIe_q, portIe_d;
  logic [7:0] portIes_q, portIes_d, pinPrev_q, pinPrev_d;
  logic [1:0] tpCtl_q, tpCtl_d;
  logic tpIfg_q, tpIfg_d, tpIe_q, tpIe_d;
  logic [EV_W-1:0] evStat_q, evStat_d, evMask_q, evMask_d;
  logic rstPend_q, rstPend_d;
  logic [15:0] vecRom [16];
  logic [15:0] vecAddr_q, vecAddr_d;
  logic [3:0] vecPri_q, vecPri_d;
  logic pend_q, pend_d, awake_q, awake_d, irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, err_q, err_d;
  vipu_core_t core_q, core_d;
  logic [7:0] edgeHit;
  logic wr, rd, known, wakeEv;

  assign wr = psel && penable && pwrite && !ready_q;
  assign rd = psel && penable && !pwrite && !ready_q;

  // ****************************************
  // Vector table contents
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_rom
      // Default handler address: slot base plus slot index times 64
      assign vecRom[gi] = 16'hC000 + 16'(gi * 64);
    end
  endgenerate

  // ****************************************
  // Edge detection per port bit
  // ****************************************
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_edge
      assign edgeHit[gi] = portIes_q[gi]
        ? (pinPrev_q[gi] && !portPins[gi])
        : (!pinPrev_q[gi] && portPins[gi]);
    end
  endgenerate

  // ****************************************
  // Flag and register next state
  // ****************************************
  always_comb
  begin
    logic tpEv;
    logic [EV_W-1:0] evSet;
    tpEv = 1'b0;
    evSet = '0;
    cmnIe_d = cmnIe_q;
    cmnIfg_d = cmnIfg_q;
    portIfg_d = portIfg_q;
    portIe_d = portIe_q;
    portIes_d = portIes_q;
    tpCtl_d = tpCtl_q;
    tpIfg_d = tpIfg_q;
    tpIe_d = tpIe_q;
    evMask_d = evMask_q;
    evStat_d = evStat_q;
    pinPrev_d = portPins;
    if (wr)
    begin
      if (hit(paddr, CMN_IE_OFS))
        cmnIe_d = pwdata[CMN_W-1:0];
      if (hit(paddr, CMN_IFG_OFS))
        cmnIfg_d = pwdata[CMN_W-1:0];
      if (hit(paddr, PORT_IFG_OFS))
        portIfg_d = pwdata[7:2];
      if (hit(paddr, PORT_IE_OFS))
        portIe_d = pwdata[7:2];
      if (hit(paddr, PORT_IES_OFS))
        portIes_d = pwdata[7:0];
      if (hit(paddr, TP_CTL_OFS))
      begin
        tpCtl_d = pwdata[1:0];
        tpIe_d = pwdata[2];
      end
      if (hit(paddr, TP_STAT_OFS))
        tpIfg_d = pwdata[0];
      if (hit(paddr, IRQ_STAT_OFS))
        evStat_d = evStat_q & ~pwdata[EV_W-1:0];
      if (hit(paddr, IRQ_MASK_OFS))
        evMask_d = pwdata[EV_W-1:0];
    end
    // tpCtl[0]=cascade, tpCtl[1]=external gate selected
    tpEv = (tpCtl_q[1] && tpGate) || tpOvfHigh;
    if (!tpCtl_q[0])
      tpEv = tpEv || tpOvfLow;
    // Hardware sets win over software writes
    if (wdtInterval)
      cmnIfg_d[WDT_BIT] = 1'b1;
    if (oscFault)
      cmnIfg_d[OF_BIT] = 1'b1;
    if (edgeHit[0])
      cmnIfg_d[P0_BIT] = 1'b1;
    if (edgeHit[1])
      cmnIfg_d[P1_BIT] = 1'b1;
    if (baseTimerTick)
      cmnIfg_d[BT_BIT] = 1'b1;
    portIfg_d = portIfg_d | edgeHit[7:2];
    if (tpEv)
      tpIfg_d = 1'b1;
    evSet = {takeIrq && pend_q, retIrq, tpEv};
    evStat_d = evStat_d | evSet;
  end

  // ****************************************
  // Arbitration and core sequence
  // ****************************************
  always_comb
  begin
    logic maskOk;
    maskOk = globalIrqEnable;
    rstPend_d = rstPend_q || extResetReq || wdtExpire;
    pend_d = 1'b1;
    vecPri_d = vecPri_q;
    // Priority order, highest first; empty slots absent
    if (rstPend_q)
      vecPri_d = PRI_RESET;
    else if (nmiReq || (cmnIfg_q[OF_BIT] && cmnIe_q[OF_BIT] && maskOk))
      vecPri_d = PRI_NMI;
    else if (maskOk && cmnIfg_q[P0_BIT] && cmnIe_q[P0_BIT])
      vecPri_d = PRI_P0;
    else if (maskOk && cmnIfg_q[P1_BIT] && cmnIe_q[P1_BIT])
      vecPri_d = PRI_P1;
    else if (maskOk && cmnIfg_q[WDT_BIT] && cmnIe_q[WDT_BIT])
      vecPri_d = PRI_WDT;
    else if (maskOk && tpIfg_q && tpIe_q)
      vecPri_d = PRI_TP;
    else if (maskOk && cmnIfg_q[BT_BIT] && cmnIe_q[BT_BIT])
      vecPri_d = PRI_BT;
    else if (maskOk && |(portIfg_q & portIe_q))
      vecPri_d = PRI_PORTHI;
    else
      pend_d = 1'b0;
    vecAddr_d = vecRom[vecPri_d];
    wakeEv = pend_q;
    core_d = core_q;
    awake_d = awake_q;
    unique case (core_q)
      CORE_RUN:
      begin
        if (takeIrq && pend_q)
          core_d = CORE_ACK;
        else if (sleepReq)
          core_d = CORE_SLEEP;
      end
      CORE_SLEEP:
      begin
        if (wakeEv)
          core_d = CORE_ACK;
      end
      CORE_ACK:
      begin
        if (retIrq)
          core_d = CORE_RUN;
      end
    endcase
    awake_d = core_d != CORE_SLEEP;
    if (takeIrq && pend_q && vecPri_q == PRI_RESET)
      rstPend_d = extResetReq || wdtExpire;
    irq_d = |(evStat_d & evMask_d);
  end

  // ****************************************
  // APB read mux
  // ****************************************
  always_comb
  begin
    rdata_d = RST_ZERO;
    known = 1'b1;
    unique case (paddr)
      CMN_IE_OFS: rdata_d[CMN_W-1:0] = cmnIe_q;
      CMN_IFG_OFS: rdata_d[CMN_W-1:0] = cmnIfg_q;
      PORT_IFG_OFS: rdata_d[7:2] = portIfg_q;
      PORT_IE_OFS: rdata_d[7:2] = portIe_q;
      PORT_IES_OFS: rdata_d[7:0] = portIes_q;
      TP_CTL_OFS: rdata_d[2:0] = {tpIe_q, tpCtl_q};
      TP_STAT_OFS: rdata_d[0] = tpIfg_q;
      CORE_CTL_OFS: rdata_d[1:0] = core_q;
      VEC_OFS: rdata_d = {11'h000, pend_q, vecPri_q, vecAddr_q};
      IRQ_STAT_OFS: rdata_d[EV_W-1:0] = evStat_q;
      IRQ_MASK_OFS: rdata_d[EV_W-1:0] = evMask_q;
      default:
      begin
        known = 1'b0;
        rdata_d = ERR_DATA;
      end
    endcase
    if (!rd)
      rdata_d = prdata;
    ready_d = psel && penable && !ready_q;
    err_d = psel && penable && !ready_q && !known;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmnIe_q <= '0;
      cmnIfg_q <= '0;
      portIfg_q <= '0;
      portIe_q <= '0;
      portIes_q <= '0;
      pinPrev_q <= '0;
      tpCtl_q <= '0;
      tpIfg_q <= 1'b0;
      tpIe_q <= 1'b0;
      evStat_q <= '0;
      evMask_q <= '0;
      rstPend_q <= 1'b1;
      vecAddr_q <= '0;
      vecPri_q <= '0;
      pend_q <= 1'b0;
      awake_q <= 1'b1;
      irq_q <= 1'b0;
      core_q <= CORE_RUN;
      prdata <= RST_ZERO;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      cmnIe_q <= cmnIe_d;
      cmnIfg_q <= cmnIfg_d;
      portIfg_q <= portIfg_d;
      portIe_q <= portIe_d;
      portIes_q <= portIes_d;
      pinPrev_q <= pinPrev_d;
      tpCtl_q <= tpCtl_d;
      tpIfg_q <= tpIfg_d;
      tpIe_q <= tpIe_d;
      evStat_q <= evStat_d;
      evMask_q <= evMask_d;
      rstPend_q <= rstPend_d;
      vecAddr_q <= vecAddr_d;
      vecPri_q <= vecPri_d;
      pend_q <= pend_d;
      awake_q <= awake_d;
      irq_q <= irq_d;
      core_q <= core_d;
      prdata <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  assign pready = ready_q;
  assign pslverr = err_q;
  assign irqPending = pend_q;
  assign vectorAddr = vecAddr_q;
  assign vectorPri = vecPri_q;
  assign coreAwake = awake_q;
  assign irq = irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_vec_range: assert property (pend_q |-> vecAddr_q == vecRom[vecPri_q])
    else $error("vector address mismatch");
  a_rst_top: assert property (extResetReq |=> ##1 (pend_q && vecPri_q == PRI_RESET))
    else $error("reset not at top priority");
  a_nmi_pri: assert property ((nmiReq && !rstPend_q) |=> vecPri_q == PRI_NMI)
    else $error("nmi not priority 14");
  a_gie_block: assert property ((pend_q && vecPri_q < PRI_NMI) |-> $past(globalIrqEnable))
    else $error("maskable taken without global enable");
  a_no_empty: assert property (pend_q |-> !(vecPri_q inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB}))
    else $error("unassigned vector selected");
  a_tp_cascade: assert property ((tpCtl_q == 2'b01 && tpOvfLow && !tpOvfHigh && !tpIfg_q && !wr) |=> !tpIfg_q)
    else $error("cascade low overflow set flag");
  a_tp_split: assert property ((!tpCtl_q[0] && tpOvfLow) |=> tpIfg_q)
    else $error("split overflow lost");
  a_wake: assert property ((core_q == CORE_SLEEP && pend_q) |=> core_q == CORE_ACK ##1 awake_q)
    else $error("no wake on interrupt");
  a_edge_set: assert property ((!portIes_q[0] && !pinPrev_q[0] && portPins[0]) |=> cmnIfg_q[P0_BIT])
    else $error("edge flag not set");

  c_reset_vec: cover property (pend_q && vecPri_q == PRI_RESET);
  c_wake: cover property (core_q == CORE_SLEEP ##1 core_q == CORE_ACK);
  c_port_hi: cover property (pend_q && vecPri_q == PRI_PORTHI);

endmodule

// [verification/vectored_interrupt_priority_unit_tb_top.sv]
// Testbench for the vectored interrupt unit: APB, events, vectors
// Assumes vipu_pkg, vipu_top and vipu_core_model compiled first
`timescale 1ns/1ps
module vectored_interrupt_priority_unit_tb_top;
  import vipu_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, portPins = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, errSeen, extResetReq = 0, wdtExpire = 0;
  logic wdtInterval = 0, nmiReq = 0, oscFault = 0, baseTimerTick = 0;
  logic tpGate = 0, tpOvfLow = 0, tpOvfHigh = 0, globalIrqEnable = 0;
  logic sleepReq = 0, takeIrq, retIrq, irqPending, coreAwake, irq;
  logic takeCmd = 0;
  logic [3:0] lag = 4'h0, vectorPri;
  logic [15:0] vectorAddr;
  int errTotal = 0, nTests = 0;
  always #4 clk = ~clk;
  vipu_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .extResetReq, .wdtExpire, .wdtInterval,
    .nmiReq, .oscFault, .baseTimerTick, .portPins, .tpGate, .tpOvfLow,
    .tpOvfHigh, .globalIrqEnable, .sleepReq, .takeIrq, .retIrq,
    .irqPending, .vectorAddr, .vectorPri, .coreAwake, .irq);
  vipu_core_model core_u (.clk, .rst, .takeCmd, .lag, .irqPending,
    .takeIrq, .retIrq);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, s);
    nTests++;
    if (s !== e)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1, {31'h0, pready});
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic takeChk(input logic [3:0] e);
    int n = 0;
    @(posedge clk);
    takeCmd <= 1'b1;
    @(posedge clk);
    takeCmd <= 1'b0;
    while (takeIrq !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk("takeIrq", 1, {31'h0, takeIrq});
    chk("vectorPri", {28'h0, e}, {28'h0, vectorPri});
    chk("vectorAddr", {16'h0, 16'hC000 + {6'h00, e, 6'h00}},
      {16'h0, vectorAddr});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    case (i)
      0: wdtInterval <= 1'b1;
      1: oscFault <= 1'b1;
      2: portPins <= 8'h01;
      3: portPins <= 8'h02;
      4: baseTimerTick <= 1'b1;
      5: tpGate <= 1'b1;
      6: tpOvfLow <= 1'b1;
      7: tpOvfHigh <= 1'b1;
      8: portPins <= 8'h20;
      9: wdtExpire <= 1'b1;
      default: extResetReq <= 1'b1;
    endcase
    @(posedge clk);
    {wdtInterval, oscFault, baseTimerTick, tpGate} <= 4'h0;
    {tpOvfLow, tpOvfHigh, wdtExpire, extResetReq} <= 4'h0;
    portPins <= 8'h00;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sReset();
    takeChk(4'hF);
    repeat (3) @(posedge clk);
    chk("irqPending", 0, {31'h0, irqPending});
    rdChk("cmnIe", CMN_IE_OFS, 32'h0);
    rdChk("cmnIfg", CMN_IFG_OFS, 32'h0);
    apb(1'b1, CMN_IE_OFS, 32'hFFFF_FFFF);
    rdChk("cmnIe", CMN_IE_OFS, 32'h1F);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 1, {31'h0, errSeen});
    chk("errData", ERR_DATA, rd);
  endtask
  task automatic sTable();
    logic [3:0] pri [0:4] = '{4'hA, 4'hE, 4'hD, 4'hC, 4'h1};
    globalIrqEnable <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      pulse(i);
      takeChk(pri[i]);
      apb(1'b1, CMN_IFG_OFS, 32'h0);
    end
    lag <= 4'h5;
    pulse(0);
    pulse(3);
    takeChk(4'hC);
    apb(1'b1, CMN_IFG_OFS, 32'h0);
    lag <= 4'h0;
    globalIrqEnable <= 1'b0;
    pulse(0);
    repeat (6) @(posedge clk);
    chk("irqPending", 0, {31'h0, irqPending});
    rdChk("cmnIfg", CMN_IFG_OFS, 32'h1);
    globalIrqEnable <= 1'b1;
    takeChk(4'hA);
    apb(1'b1, CMN_IFG_OFS, 32'h0);
    pulse(9);
    takeChk(4'hF);
    pulse(10);
    takeChk(4'hF);
  endtask
  task automatic sTimer();
    apb(1'b1, TP_CTL_OFS, 32'h6);
    for (int i = 5; i < 8; i++)
    begin
      pulse(i);
      takeChk(4'h5);
      rdChk("tpFlag", TP_STAT_OFS, 32'h1);
      apb(1'b1, TP_STAT_OFS, 32'h0);
    end
    apb(1'b1, TP_CTL_OFS, 32'h7);
    pulse(6);
    repeat (6) @(posedge clk);
    chk("irqPending", 0, {31'h0, irqPending});
    pulse(5);
    takeChk(4'h5);
    apb(1'b1, TP_STAT_OFS, 32'h0);
  endtask
  task automatic sPort();
    apb(1'b1, PORT_IES_OFS, 32'h20);
    apb(1'b1, PORT_IE_OFS, 32'hFF);
    rdChk("portIe", PORT_IE_OFS, 32'hFC);
    pulse(8);
    takeChk(4'h0);
    rdChk("vecReg", VEC_OFS, 32'h0010_C000);
    rdChk("portIfg", PORT_IFG_OFS, 32'h20);
    apb(1'b1, PORT_IFG_OFS, 32'h0);
  endtask
  task automatic sNmi();
    globalIrqEnable <= 1'b0;
    apb(1'b1, IRQ_STAT_OFS, 32'hFFFF_FFFF);
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("coreAwake", 0, {31'h0, coreAwake});
    nmiReq <= 1'b1;
    takeChk(4'hE);
    nmiReq <= 1'b0;
    repeat (6) @(posedge clk);
    chk("coreAwake", 1, {31'h0, coreAwake});
    chk("irq", 1, {31'h0, irq});
    apb(1'b1, IRQ_STAT_OFS, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
  endtask
  task automatic printVerdict();
    if (errTotal == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    sReset();
    sTable();
    sTimer();
    sPort();
    sNmi();
    printVerdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errTotal++;
    printVerdict();
  end
endmodule

// [verification/vipu_core_model.sv]
// Core stand-in: accepts pending vectors on command, then returns
// Assumes the unit's clk and rst; vectors may re-arbitrate while irqPending is high
`timescale 1ns/1ps
module vipu_core_model
  import vipu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic takeCmd,
  input wire logic [3:0] lag,
  input wire logic irqPending,
  output logic takeIrq,
  output logic retIrq
);
  // ****************************************
  // Accept after lag cycles, return later
  // ****************************************
  logic armed;
  logic [3:0] cnt;
  logic [1:0] retCnt;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      armed <= 1'b0;
      cnt <= 4'h0;
      retCnt <= 2'h0;
      takeIrq <= 1'b0;
      retIrq <= 1'b0;
    end
    else
    begin
      takeIrq <= 1'b0;
      retIrq <= (retCnt == 2'h1);
      if (retCnt != 2'h0)
        retCnt <= retCnt - 2'h1;
      if (takeCmd)
      begin
        armed <= 1'b1;
        cnt <= lag;
      end
      else if (armed && irqPending)
      begin
        if (cnt != 4'h0)
          cnt <= cnt - 4'h1;
        else
        begin
          takeIrq <= 1'b1;
          armed <= 1'b0;
          retCnt <= 2'h3;
        end
      end
    end
  end
endmodule
